// *** mcq_pkg.sv ***
// constants, encodings and state type of the mailbox command queue engine
// assumes a byte-wide host memory master and a single scsi executor outside
`default_nettype none

package mcq_pkg;

	////////////////////////////////////////////////////////////////////////
	// outgoing action codes
	localparam logic [7:0] ACT_FREE  = 8'h00;
	localparam logic [7:0] ACT_START = 8'h01;
	localparam logic [7:0] ACT_ABORT = 8'h02;

	// incoming completion codes
	localparam logic [7:0] CC_FREE     = 8'h00;
	localparam logic [7:0] CC_OK       = 8'h01;
	localparam logic [7:0] CC_ABORTED  = 8'h02;
	localparam logic [7:0] CC_NOTFOUND = 8'h03;
	localparam logic [7:0] CC_ERROR    = 8'h04;

	////////////////////////////////////////////////////////////////////////
	// register indices
	localparam logic [2:0] REG_CTRL   = 3'h0;
	localparam logic [2:0] REG_COUNT  = 3'h1;
	localparam logic [2:0] REG_BASE   = 3'h2;
	localparam logic [2:0] REG_INT    = 3'h3;
	localparam logic [2:0] REG_STATUS = 3'h4;

	// control register fields
	localparam int CTRL_START_BIT  = 0;
	localparam int CTRL_OUT_EN_BIT = 1;
	localparam int CTRL_SENSE_BIT  = 2;

	// interrupt register fields
	localparam int INT_OUT_BIT   = 0;
	localparam int INT_IN_BIT    = 1;
	localparam int INT_OTHER_BIT = 2;
	localparam int INT_VALID_BIT = 7;

	////////////////////////////////////////////////////////////////////////
	// queue and command block layout
	localparam int         QDEPTH         = 32;
	localparam logic [4:0] CB_FETCH_LAST  = 5'h11;
	localparam logic [4:0] CB_AST_OFS     = 5'h0E;
	localparam logic [4:0] CB_DST_OFS     = 5'h0F;
	localparam logic [4:0] SLOT_LAST_BYTE = 5'h03;

	// executor completion results
	localparam logic [1:0] RES_GOOD  = 2'h0;
	localparam logic [1:0] RES_ERROR = 2'h1;
	localparam logic [1:0] RES_BUSY  = 2'h2;
	localparam logic [1:0] RES_CHECK = 2'h3;

	// reset values
	localparam logic [7:0]  COUNT_RST = 8'h01;
	localparam logic [23:0] BASE_RST  = 24'h000000;

	typedef enum logic [3:0] {
		S_IDLE     = 4'h0,
		S_OUT_RD   = 4'h1,
		S_OUT_FREE = 4'h3,
		S_CB_RD    = 4'h2,
		S_ABORT    = 4'h6,
		S_ST_WR    = 4'h7,
		S_IN_CHK   = 4'h5,
		S_IN_WR    = 4'h4
	} mcq_state_type;

endpackage : mcq_pkg

`default_nettype wire

// *** mcq_cmd_queue.sv ***
// circular queue of fetched command block pointers with abort search
// assumes the caller never pushes more entries than it has ids
`timescale 1ns/1ps
`default_nettype none

module mcq_cmd_queue (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// tail side
	input  wire logic        push,
	input  wire logic [23:0] push_ptr,
	input  wire logic [4:0]  push_id,
	// head side
	input  wire logic        pop,
	output logic             head_valid,
	output logic      [23:0] head_ptr,
	output logic      [4:0]  head_id,
	output logic             head_dead,
	// abort search and entry count
	input  wire logic        kill,
	input  wire logic [23:0] kill_ptr,
	output logic             kill_hit,
	output logic      [5:0]  count
);

	typedef struct packed {
		logic [mcq_pkg::QDEPTH-1:0][23:0] ptr;
		logic [mcq_pkg::QDEPTH-1:0][4:0]  id;
		logic [mcq_pkg::QDEPTH-1:0]       valid;
		logic [mcq_pkg::QDEPTH-1:0]       dead;
		logic [4:0]                       wr;
		logic [4:0]                       rd;
		logic [5:0]                       cnt;
	} mcq_queue_type;

	mcq_queue_type q;
	mcq_queue_type n;
	logic [mcq_pkg::QDEPTH-1:0] hit_vec;

	////////////////////////////////////////////////////////////////////////
	// per-entry search; a killed entry stays in place and is skipped at the head
	genvar gi;
	generate
		for (gi = 0; gi < mcq_pkg::QDEPTH; gi++) begin : g_entry
			assign hit_vec[gi] = q.valid[gi] & ~q.dead[gi] & (q.ptr[gi] == kill_ptr);
		end
	endgenerate

	assign kill_hit   = kill & (|hit_vec);
	assign head_valid = q.valid[q.rd];
	assign head_ptr   = q.ptr[q.rd];
	assign head_id    = q.id[q.rd];
	assign head_dead  = q.dead[q.rd];
	assign count      = q.cnt;

	always_comb begin
		n = q;
		if (kill) begin
			n.dead = q.dead | hit_vec;
		end
		if (pop && q.valid[q.rd]) begin
			n.valid[q.rd] = 1'b0;
			n.dead[q.rd]  = 1'b0;
			n.rd          = q.rd + 5'h01;
		end
		if (push) begin
			n.valid[q.wr] = 1'b1;
			n.dead[q.wr]  = 1'b0;
			n.ptr[q.wr]   = push_ptr;
			n.id[q.wr]    = push_id;
			n.wr          = q.wr + 5'h01;
		end
		n.cnt = q.cnt + {5'h00, push} - {5'h00, pop & q.valid[q.rd]};
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

endmodule : mcq_cmd_queue

`default_nettype wire

// *** mcq_mailbox_engine.sv ***
// mailbox engine: outgoing scan, command block fetch, queue, dispatch, completion posting
// assumes a byte-wide host memory master that answers each request with one MEM_ACK pulse
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module mcq_mailbox_engine (
	// clock and reset
	input  wire logic        MCLK,
	input  wire logic        RESET,
	// register port
	input  wire logic [2:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [31:0] REG_RDATA,
	// host memory master
	output logic             MEM_REQ,
	output logic             MEM_WRITE,
	output logic      [23:0] MEM_ADDR,
	output logic      [7:0]  MEM_WDATA,
	input  wire logic [7:0]  MEM_RDATA,
	input  wire logic        MEM_ACK,
	// local command block memory
	output logic             LRAM_WE,
	output logic      [9:0]  LRAM_ADDR,
	output logic      [7:0]  LRAM_WDATA,
	// scsi executor
	output logic             DISP_VALID,
	output logic             DISP_SENSE,
	output logic      [23:0] DISP_PTR,
	output logic      [4:0]  DISP_ID,
	input  wire logic        DISP_READY,
	output logic             ABORT_ACTIVE,
	input  wire logic        CMPL_VALID,
	input  wire logic [1:0]  CMPL_RESULT,
	input  wire logic [7:0]  CMPL_ADAPTER_STATUS,
	input  wire logic [7:0]  CMPL_DEVICE_STATUS,
	// interrupt
	input  wire logic        OTHER_EVENT,
	output logic             IRQ
);

	typedef struct packed {
		mcq_pkg::mcq_state_type st;
		logic        mem_req;
		logic        mem_we;
		logic [23:0] mem_addr;
		logic [7:0]  mem_wdata;
		logic [4:0]  byte_cnt;
		logic [7:0]  out_idx;
		logic [7:0]  in_idx;
		logic [7:0]  slot_act;
		logic [23:0] slot_ptr;
		logic [4:0]  cur_id;
		logic        scan_req;
		logic        en_out;
		logic        en_sense;
		logic [7:0]  mb_count;
		logic [23:0] mb_base;
		logic        outgoing_slot_released_flag;
		logic        incoming_slot_posted_flag;
		logic        other_flag;
		logic        interrupt_valid_flag;
		logic        out_note;
		logic        in_note;
		logic [31:0] rdata;
		logic        lram_we;
		logic [9:0]  lram_addr;
		logic [7:0]  lram_wdata;
		logic [31:0] ids_used;
		logic        act_valid;
		logic [23:0] act_ptr;
		logic [4:0]  act_id;
		logic        act_abort;
		logic        act_sensed;
		logic        disp_valid;
		logic        disp_sense;
		logic        cmp_pend;
		logic [1:0]  cmp_res;
		logic [7:0]  adapter_completion_status;
		logic [7:0]  target_device_status;
		logic [23:0] post_ptr;
		logic [7:0]  post_code;
		logic [7:0]  post_ast;
		logic [7:0]  post_dst;
	} mcq_engine_type;

	mcq_engine_type s;
	mcq_engine_type n;

	logic        q_push;
	logic [23:0] q_push_ptr;
	logic [4:0]  q_push_id;
	logic        q_pop;
	logic        q_kill;
	logic        q_head_valid;
	logic [23:0] q_head_ptr;
	logic [4:0]  q_head_id;
	logic        q_head_dead;
	logic        q_kill_hit;
	logic [5:0]  q_count;
	logic [23:0] out_slot;
	logic [23:0] in_slot;
	logic        ack;

	function automatic logic [4:0] mcq_first_free(input logic [31:0] used);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (!used[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction : mcq_first_free

	mcq_cmd_queue u_queue (
		.clk        (MCLK),
		.rst        (RESET),
		.push       (q_push),
		.push_ptr   (q_push_ptr),
		.push_id    (q_push_id),
		.pop        (q_pop),
		.head_valid (q_head_valid),
		.head_ptr   (q_head_ptr),
		.head_id    (q_head_id),
		.head_dead  (q_head_dead),
		.kill       (q_kill),
		.kill_ptr   (s.slot_ptr),
		.kill_hit   (q_kill_hit),
		.count      (q_count)
	);

	////////////////////////////////////////////////////////////////////////
	// slot addresses: incoming ring sits right after the outgoing ring
	assign out_slot = s.mb_base + {14'h0000, s.out_idx, 2'h0};
	assign in_slot  = s.mb_base + {14'h0000, s.mb_count, 2'h0} + {14'h0000, s.in_idx, 2'h0};
	assign ack      = s.mem_req & MEM_ACK;

	always_comb begin
		n          = s;
		q_push     = 1'b0;
		q_push_ptr = s.slot_ptr;
		q_push_id  = s.cur_id;
		q_pop      = 1'b0;
		q_kill     = 1'b0;
		n.lram_we  = 1'b0;
		n.rdata    = 32'h00000000;
		if (ack) begin
			n.mem_req = 1'b0;
		end

		// main sequencer; completions take priority over scanning
		case (s.st)
			mcq_pkg::S_IDLE: begin
				n.byte_cnt = 5'h00;
				if (s.cmp_pend) begin
					n.cmp_pend = 1'b0;
					if (s.cmp_res == mcq_pkg::RES_BUSY && !s.act_abort) begin
						q_push      = 1'b1;
						q_push_ptr  = s.act_ptr;
						q_push_id   = s.act_id;
						n.act_valid = 1'b0;
					end else if (s.cmp_res == mcq_pkg::RES_CHECK && s.en_sense && !s.act_sensed && !s.act_abort) begin
						n.disp_valid = 1'b1;
						n.disp_sense = 1'b1;
						n.act_sensed = 1'b1;
					end else begin
						n.post_ptr  = s.act_ptr;
						n.post_ast  = s.adapter_completion_status;
						n.post_dst  = s.target_device_status;
						n.post_code = s.act_abort ? mcq_pkg::CC_ABORTED :
							(s.cmp_res == mcq_pkg::RES_GOOD ? mcq_pkg::CC_OK : mcq_pkg::CC_ERROR);
						n.ids_used[s.act_id] = 1'b0;
						n.act_valid = 1'b0;
						n.act_abort = 1'b0;
						n.st        = mcq_pkg::S_ST_WR;
					end
				end else if (s.scan_req && !(&s.ids_used)) begin
					n.st = mcq_pkg::S_OUT_RD;
				end
			end
			mcq_pkg::S_OUT_RD: begin
				if (!s.mem_req) begin
					n.mem_req  = 1'b1;
					n.mem_we   = 1'b0;
					n.mem_addr = out_slot + {19'h00000, s.byte_cnt};
				end else if (ack) begin
					n.byte_cnt = s.byte_cnt + 5'h01;
					if (s.byte_cnt == 5'h00) begin
						n.slot_act = MEM_RDATA;
						if (MEM_RDATA == mcq_pkg::ACT_FREE) begin
							n.scan_req = 1'b0;
							n.st       = mcq_pkg::S_IDLE;
						end
					end else begin
						n.slot_ptr = {s.slot_ptr[15:0], MEM_RDATA};
						if (s.byte_cnt == mcq_pkg::SLOT_LAST_BYTE) begin
							n.st = mcq_pkg::S_OUT_FREE;
						end
					end
				end
			end
			mcq_pkg::S_OUT_FREE: begin
				if (!s.mem_req) begin
					n.mem_req   = 1'b1;
					n.mem_we    = 1'b1;
					n.mem_addr  = out_slot;
					n.mem_wdata = mcq_pkg::ACT_FREE;
				end else if (ack) begin
					n.out_note = s.out_note | s.en_out;
					n.out_idx  = (s.out_idx + 8'h01 >= s.mb_count) ? 8'h00 : s.out_idx + 8'h01;
					n.byte_cnt = 5'h00;
					if (s.slot_act == mcq_pkg::ACT_ABORT) begin
						n.st = mcq_pkg::S_ABORT;
					end else if (s.slot_act == mcq_pkg::ACT_START) begin
						n.cur_id = mcq_first_free(s.ids_used);
						n.ids_used[mcq_first_free(s.ids_used)] = 1'b1;
						n.st = mcq_pkg::S_CB_RD;
					end else begin
						n.st = mcq_pkg::S_IDLE;
					end
				end
			end
			mcq_pkg::S_CB_RD: begin
				if (!s.mem_req) begin
					n.mem_req  = 1'b1;
					n.mem_we   = 1'b0;
					n.mem_addr = s.slot_ptr + {19'h00000, s.byte_cnt};
				end else if (ack) begin
					n.lram_we    = 1'b1;
					n.lram_addr  = {s.cur_id, s.byte_cnt};
					n.lram_wdata = MEM_RDATA;
					n.byte_cnt   = s.byte_cnt + 5'h01;
					if (s.byte_cnt == mcq_pkg::CB_FETCH_LAST) begin
						q_push = 1'b1;
						n.st   = mcq_pkg::S_IDLE;
					end
				end
			end
			mcq_pkg::S_ABORT: begin
				q_kill      = 1'b1;
				n.post_ptr  = s.slot_ptr;
				n.post_ast  = 8'h00;
				n.post_dst  = 8'h00;
				n.st        = mcq_pkg::S_IN_CHK;
				if (q_kill_hit) begin
					n.post_code = mcq_pkg::CC_ABORTED;
				end else if (s.act_valid && !s.act_abort && s.act_ptr == s.slot_ptr) begin
					n.act_abort = 1'b1;
					n.st        = mcq_pkg::S_IDLE;
				end else begin
					n.post_code = mcq_pkg::CC_NOTFOUND;
				end
			end
			mcq_pkg::S_ST_WR: begin
				if (!s.mem_req) begin
					n.mem_req   = 1'b1;
					n.mem_we    = 1'b1;
					n.mem_addr  = s.post_ptr + {19'h00000, s.byte_cnt[0] ? mcq_pkg::CB_DST_OFS : mcq_pkg::CB_AST_OFS};
					n.mem_wdata = s.byte_cnt[0] ? s.post_dst : s.post_ast;
				end else if (ack) begin
					n.byte_cnt = s.byte_cnt + 5'h01;
					if (s.byte_cnt[0]) begin
						n.st = mcq_pkg::S_IN_CHK;
					end
				end
			end
			mcq_pkg::S_IN_CHK: begin
				if (!s.mem_req) begin
					n.mem_req  = 1'b1;
					n.mem_we   = 1'b0;
					n.mem_addr = in_slot;
				end else if (ack && MEM_RDATA == mcq_pkg::CC_FREE) begin
					n.byte_cnt = 5'h01;
					n.st       = mcq_pkg::S_IN_WR;
				end
			end
			mcq_pkg::S_IN_WR: begin
				if (!s.mem_req) begin
					n.mem_req  = 1'b1;
					n.mem_we   = 1'b1;
					n.mem_addr = in_slot + {19'h00000, s.byte_cnt};
					case (s.byte_cnt[1:0])
						2'h1:    n.mem_wdata = s.post_ptr[23:16];
						2'h2:    n.mem_wdata = s.post_ptr[15:8];
						2'h3:    n.mem_wdata = s.post_ptr[7:0];
						default: n.mem_wdata = s.post_code;
					endcase
				end else if (ack) begin
					if (s.byte_cnt == 5'h00) begin
						n.in_note = 1'b1;
						n.in_idx  = (s.in_idx + 8'h01 >= s.mb_count) ? 8'h00 : s.in_idx + 8'h01;
						n.st      = mcq_pkg::S_IDLE;
					end else begin
						n.byte_cnt = (s.byte_cnt == mcq_pkg::SLOT_LAST_BYTE) ? 5'h00 : s.byte_cnt + 5'h01;
					end
				end
			end
			default: begin
				n.st      = mcq_pkg::S_IDLE;
				n.mem_req = 1'b0;
			end
		endcase

		////////////////////////////////////////////////////////////////////
		// dispatch: one command on the bus at a time; killed heads are dropped
		if (s.disp_valid && DISP_READY) begin
			n.disp_valid = 1'b0;
		end
		if (!s.act_valid && !s.disp_valid && q_head_valid && s.st != mcq_pkg::S_ABORT) begin
			q_pop = 1'b1;
			if (q_head_dead) begin
				n.ids_used[q_head_id] = 1'b0;
			end else begin
				n.act_valid  = 1'b1;
				n.act_ptr    = q_head_ptr;
				n.act_id     = q_head_id;
				n.act_abort  = 1'b0;
				n.act_sensed = 1'b0;
				n.disp_valid = 1'b1;
				n.disp_sense = 1'b0;
			end
		end

		// a late completion is held until the sequencer is idle
		if (CMPL_VALID) begin
			n.cmp_pend                  = 1'b1;
			n.cmp_res                   = CMPL_RESULT;
			n.adapter_completion_status = CMPL_ADAPTER_STATUS;
			n.target_device_status      = CMPL_DEVICE_STATUS;
		end

		////////////////////////////////////////////////////////////////////
		// register writes come after the sequencer so a start is never lost
		if (REG_WR) begin
			case (REG_ADDR)
				mcq_pkg::REG_CTRL: begin
					n.scan_req = n.scan_req | REG_WDATA[mcq_pkg::CTRL_START_BIT];
					n.en_out   = REG_WDATA[mcq_pkg::CTRL_OUT_EN_BIT];
					n.en_sense = REG_WDATA[mcq_pkg::CTRL_SENSE_BIT];
				end
				mcq_pkg::REG_COUNT: begin
					n.mb_count = REG_WDATA[7:0];
					n.out_idx  = 8'h00;
					n.in_idx   = 8'h00;
				end
				mcq_pkg::REG_BASE: begin
					n.mb_base = REG_WDATA[23:0];
					n.out_idx = 8'h00;
					n.in_idx  = 8'h00;
				end
				mcq_pkg::REG_INT: begin
					// write one to clear; sets below win over a same-cycle clear
					if (REG_WDATA[mcq_pkg::INT_OUT_BIT]) n.outgoing_slot_released_flag = 1'b0;
					if (REG_WDATA[mcq_pkg::INT_IN_BIT]) n.incoming_slot_posted_flag = 1'b0;
					if (REG_WDATA[mcq_pkg::INT_OTHER_BIT]) n.other_flag = 1'b0;
					if (REG_WDATA[mcq_pkg::INT_VALID_BIT]) n.interrupt_valid_flag = 1'b0;
				end
				default: begin
				end
			endcase
		end

		////////////////////////////////////////////////////////////////////
		// notification merge
		if (OTHER_EVENT) begin
			n.other_flag           = 1'b1;
			n.interrupt_valid_flag = 1'b1;
		end
		if (n.in_note) begin
			if (n.incoming_slot_posted_flag) begin
				n.in_note = 1'b0;
			end else if (!n.outgoing_slot_released_flag && !n.other_flag && !n.interrupt_valid_flag) begin
				n.incoming_slot_posted_flag = 1'b1;
				n.interrupt_valid_flag      = 1'b1;
				n.in_note                   = 1'b0;
			end
		end
		if (n.out_note) begin
			if (n.outgoing_slot_released_flag) begin
				n.out_note = 1'b0;
			end else if (!n.incoming_slot_posted_flag && !n.other_flag && !n.interrupt_valid_flag) begin
				n.outgoing_slot_released_flag = 1'b1;
				n.interrupt_valid_flag        = 1'b1;
				n.out_note                    = 1'b0;
			end
		end

		// read data stand in the next cycle only
		if (REG_RD) begin
			case (REG_ADDR)
				mcq_pkg::REG_CTRL:   n.rdata = {29'h00000000, s.en_sense, s.en_out, s.scan_req};
				mcq_pkg::REG_COUNT:  n.rdata = {24'h000000, s.mb_count};
				mcq_pkg::REG_BASE:   n.rdata = {8'h00, s.mb_base};
				mcq_pkg::REG_INT:    n.rdata = {24'h000000, s.interrupt_valid_flag, 4'h0, s.other_flag,
					s.incoming_slot_posted_flag, s.outgoing_slot_released_flag};
				mcq_pkg::REG_STATUS: n.rdata = {18'h00000, q_count, 3'h0, s.act_valid, s.st};
				default:             n.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			s          <= '0;
			s.st       <= mcq_pkg::S_IDLE;
			s.mb_count <= mcq_pkg::COUNT_RST;
			s.mb_base  <= mcq_pkg::BASE_RST;
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from state
	assign REG_RDATA    = s.rdata;
	assign MEM_REQ      = s.mem_req;
	assign MEM_WRITE    = s.mem_we;
	assign MEM_ADDR     = s.mem_addr;
	assign MEM_WDATA    = s.mem_wdata;
	assign LRAM_WE      = s.lram_we;
	assign LRAM_ADDR    = s.lram_addr;
	assign LRAM_WDATA   = s.lram_wdata;
	assign DISP_VALID   = s.disp_valid;
	assign DISP_SENSE   = s.disp_sense;
	assign DISP_PTR     = s.act_ptr;
	assign DISP_ID      = s.act_id;
	assign ABORT_ACTIVE = s.act_abort;
	assign IRQ          = s.interrupt_valid_flag;

endmodule : mcq_mailbox_engine

`default_nettype wire

// *** mcq_sva.sv ***
// port assertions for the mailbox engine
// assumes binding into mcq_mailbox_engine, one clock domain
`timescale 1ns/1ps
`default_nettype none
module mcq_sva (
	// clock, reset, register port
	input wire logic        MCLK,
	input wire logic        RESET,
	input wire logic [2:0]  REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [31:0] REG_RDATA,
	// memory, executor, interrupt
	input wire logic        MEM_REQ,
	input wire logic        MEM_WRITE,
	input wire logic [23:0] MEM_ADDR,
	input wire logic [7:0]  MEM_WDATA,
	input wire logic        MEM_ACK,
	input wire logic        DISP_VALID,
	input wire logic        DISP_READY,
	input wire logic [23:0] DISP_PTR,
	input wire logic [4:0]  DISP_ID,
	input wire logic        CMPL_VALID,
	input wire logic [1:0]  CMPL_RESULT,
	input wire logic [7:0]  CMPL_ADAPTER_STATUS,
	input wire logic        OTHER_EVENT,
	input wire logic        IRQ
);
	logic [23:0] cptr_r;
	logic [7:0]  ast_r;
	logic        ev;
	assign ev = (MEM_ACK && MEM_WRITE) || REG_WR || OTHER_EVENT;
	// pointer kept past completion, the engine may move on
	always_ff @(posedge MCLK) begin
		if (CMPL_VALID) begin
			cptr_r <= DISP_PTR;
			ast_r  <= CMPL_ADAPTER_STATUS;
		end
	end
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RESET);
	sequence st_wr;
		MEM_REQ && MEM_WRITE && MEM_ADDR == cptr_r + 24'h00000E && MEM_WDATA == ast_r;
	endsequence
	////////////////////////////////////////////////////////////////////////
	mem_hold_a: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR)
		&& $stable(MEM_WRITE) && $stable(MEM_WDATA)) else $error("memory request moved");
	mem_drop_a: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ)
		else $error("memory request not dropped");
	disp_hold_a: assert property (DISP_VALID && !DISP_READY |=> DISP_VALID
		&& $stable(DISP_PTR) && $stable(DISP_ID)) else $error("dispatch offer moved");
	disp_drop_a: assert property (DISP_VALID && DISP_READY |=> !DISP_VALID)
		else $error("dispatch offer kept");
	rd_idle_a: assert property (!REG_RD |=> REG_RDATA == 32'h00000000)
		else $error("read data outside read slot");
	irq_cause_a: assert property ($rose(IRQ) |-> $past(ev) || $past(ev, 2))
		else $error("interrupt without cause");
	irq_clr_a: assert property ($fell(IRQ) |-> $past(REG_WR && REG_ADDR == mcq_pkg::REG_INT
		&& REG_WDATA[mcq_pkg::INT_VALID_BIT])) else $error("interrupt dropped alone");
	stat_first_a: assert property (CMPL_VALID && CMPL_RESULT == mcq_pkg::RES_GOOD
		|-> ##[1:300] st_wr) else $error("status not written");
endmodule : mcq_sva
bind mcq_mailbox_engine mcq_sva mcq_sva_inst (.MCLK, .RESET, .REG_ADDR, .REG_WDATA, .REG_WR,
	.REG_RD, .REG_RDATA, .MEM_REQ, .MEM_WRITE, .MEM_ADDR, .MEM_WDATA, .MEM_ACK, .DISP_VALID,
	.DISP_READY, .DISP_PTR, .DISP_ID, .CMPL_VALID, .CMPL_RESULT, .CMPL_ADAPTER_STATUS,
	.OTHER_EVENT, .IRQ);
`default_nettype wire

// *** mcq_host_mem.sv ***
// host main memory answering the engine's byte master
// assumes one request at a time, held until acknowledged
`timescale 1ns/1ps
`default_nettype none
module mcq_host_mem (
	// clock and pace
	input  wire logic        clk,
	input  wire logic        slow,
	// byte master port
	input  wire logic        req,
	input  wire logic        we,
	input  wire logic [23:0] addr,
	input  wire logic [7:0]  wdata,
	output logic      [7:0]  rdata,
	output logic             ack
);
	logic [7:0] mem [0:255];
	logic [1:0] wait_r;
	initial begin
		ack = 1'b0;
		rdata = 8'h00;
		wait_r = 2'h0;
		foreach (mem[i]) mem[i] = 8'h00;
	end
	always @(posedge clk) begin
		ack <= 1'b0;
		rdata <= ~rdata; // stale byte never looks valid
		if (req && !ack) begin
			wait_r <= wait_r + 2'h1;
			if (wait_r >= {slow, slow}) begin
				ack <= 1'b1;
				wait_r <= 2'h0;
				if (we) mem[addr[7:0]] <= wdata;
				else rdata <= mem[addr[7:0]];
			end
		end
	end
endmodule : mcq_host_mem
`default_nettype wire

// *** tb_top.sv ***
// bench playing host driver and scsi executor
// assumes mcq_host_mem as memory, slots at 40h, blocks at 80h up
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        mclk, reset, reg_wr, reg_rd, slow, mem_req, mem_write, mem_ack;
	logic        disp_valid, disp_ready, cmpl_valid, other_event, irq, abort_active;
	logic [1:0]  cmpl_result;
	logic [2:0]  reg_addr;
	logic [7:0]  mem_wdata, mem_rdata, ast;
	logic [23:0] mem_addr, disp_ptr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	int          errors, n_tests;
	mcq_mailbox_engine mcq_mailbox_engine_inst (
		.MCLK(mclk), .RESET(reset), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_RDATA(reg_rdata), .MEM_REQ(mem_req), .MEM_WRITE(mem_write),
		.MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack),
		.LRAM_WE(), .LRAM_ADDR(), .LRAM_WDATA(), .DISP_VALID(disp_valid), .DISP_SENSE(),
		.DISP_PTR(disp_ptr), .DISP_ID(), .DISP_READY(disp_ready), .ABORT_ACTIVE(abort_active),
		.CMPL_VALID(cmpl_valid), .CMPL_RESULT(cmpl_result), .CMPL_ADAPTER_STATUS(ast),
		.CMPL_DEVICE_STATUS(~ast), .OTHER_EVENT(other_event), .IRQ(irq));
	mcq_host_mem mcq_host_mem_inst (.clk(mclk), .slow(slow), .req(mem_req), .we(mem_write),
		.addr(mem_addr), .wdata(mem_wdata), .rdata(mem_rdata), .ack(mem_ack));
	////////////////////////////////////////////////////////////////////////
	task automatic results;
		if (errors == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [7:0] mb(input int a);
		return mcq_host_mem_inst.mem[a];
	endfunction : mb
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		rv = reg_rdata;
	endtask : rd
	// pointer first, action byte last
	task automatic put(input int a, input logic [7:0] act, input logic [23:0] p);
		{mcq_host_mem_inst.mem[a+1], mcq_host_mem_inst.mem[a+2], mcq_host_mem_inst.mem[a+3]} = p;
		mcq_host_mem_inst.mem[a] = act;
	endtask : put
	task automatic wait_in(input int a, input logic [7:0] c, input logic [23:0] p);
		int k;
		for (k = 0; mb(a) === 8'h00 && k < 3000; k++) @(negedge mclk);
		chk(mb(a), c);
		chk({mb(a+1), mb(a+2), mb(a+3)}, p);
		mcq_host_mem_inst.mem[a] = 8'h00;
	endtask : wait_in
	task automatic accept(input logic [23:0] p);
		int k;
		for (k = 0; disp_valid !== 1'b1 && k < 3000; k++) @(negedge mclk);
		chk({disp_valid, disp_ptr}, {1'b1, p});
		@(posedge mclk);
		disp_ready <= 1'b1;
		@(posedge mclk);
		disp_ready <= 1'b0;
	endtask : accept
	task automatic done(input logic [23:0] p, input logic [1:0] r);
		repeat (3) @(posedge mclk);
		cmpl_valid <= 1'b1;
		cmpl_result <= r;
		ast <= p[7:0] ^ 8'h5A;
		@(posedge mclk);
		cmpl_valid <= 1'b0;
	endtask : done
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rd(mcq_pkg::REG_COUNT);
		chk(rv, 32'h00000001);
		wr(3'h7, 32'hFFFFFFFF);
		rd(3'h7);
		chk(rv, 32'h00000000);
		wr(mcq_pkg::REG_COUNT, 32'h00000002);
		wr(mcq_pkg::REG_BASE, 32'h00000040);
		rd(mcq_pkg::REG_BASE);
		chk(rv, 32'h00000040);
	endtask : t_regs
	task automatic t_first;
		put(8'h40, mcq_pkg::ACT_START, 24'h000080);
		wr(mcq_pkg::REG_CTRL, 32'h00000003);
		accept(24'h000080);
		chk(mb(8'h40), 8'h00);
		done(24'h000080, mcq_pkg::RES_GOOD);
		wait_in(8'h48, mcq_pkg::CC_OK, 24'h000080);
		chk({mb(8'h8E), mb(8'h8F)}, 16'hDA25);
		rd(mcq_pkg::REG_INT);
		chk(rv, 32'h00000081);
		chk(irq, 1'b1);
		wr(mcq_pkg::REG_INT, 32'h00000081);
		rd(mcq_pkg::REG_INT);
		chk(rv, 32'h00000082);
		wr(mcq_pkg::REG_INT, 32'h00000082);
	endtask : t_first
	task automatic t_busy;
		int k;
		slow <= 1'b1;
		put(8'h44, mcq_pkg::ACT_START, 24'h0000A0);
		put(8'h40, mcq_pkg::ACT_START, 24'h000080);
		wr(mcq_pkg::REG_CTRL, 32'h00000003);
		rv = 32'h00000000;
		// the active command leaves the queue: one active, one queued
		for (k = 0; rv[13:4] !== 10'h011 && k < 200; k++) rd(mcq_pkg::REG_STATUS);
		chk(rv[13:4], 10'h011);
		accept(24'h0000A0);
		done(24'h0000A0, mcq_pkg::RES_BUSY);
		accept(24'h000080);
		done(24'h000080, mcq_pkg::RES_GOOD);
		accept(24'h0000A0);
		done(24'h0000A0, mcq_pkg::RES_GOOD);
		wait_in(8'h4C, mcq_pkg::CC_OK, 24'h000080);
		wait_in(8'h48, mcq_pkg::CC_OK, 24'h0000A0);
		wr(mcq_pkg::REG_INT, 32'h000000FF);
		rd(mcq_pkg::REG_INT);
		chk(rv, 32'h00000082);
		wr(mcq_pkg::REG_INT, 32'h000000FF);
	endtask : t_busy
	task automatic t_notfound;
		@(posedge mclk);
		other_event <= 1'b1;
		@(posedge mclk);
		other_event <= 1'b0;
		put(8'h44, mcq_pkg::ACT_ABORT, 24'h0000C0);
		wr(mcq_pkg::REG_CTRL, 32'h00000001);
		wait_in(8'h4C, mcq_pkg::CC_NOTFOUND, 24'h0000C0);
		rd(mcq_pkg::REG_INT);
		chk(rv[2:1], 2'b10);
		wr(mcq_pkg::REG_INT, 32'h000000FF);
		rd(mcq_pkg::REG_INT);
		chk(rv, 32'h00000082);
		wr(mcq_pkg::REG_INT, 32'h000000FF);
	endtask : t_notfound
	// queued block aborted first, then the active one
	task automatic t_abort;
		int k;
		slow <= 1'b0;
		put(8'h40, mcq_pkg::ACT_START, 24'h0000A0);
		put(8'h44, mcq_pkg::ACT_START, 24'h000080);
		wr(mcq_pkg::REG_CTRL, 32'h00000001);
		accept(24'h0000A0);
		for (k = 0; mb(8'h44) !== 8'h00 && k < 3000; k++) @(negedge mclk);
		put(8'h40, mcq_pkg::ACT_ABORT, 24'h000080);
		wr(mcq_pkg::REG_CTRL, 32'h00000001);
		wait_in(8'h48, mcq_pkg::CC_ABORTED, 24'h000080);
		put(8'h44, mcq_pkg::ACT_ABORT, 24'h0000A0);
		wr(mcq_pkg::REG_CTRL, 32'h00000001);
		for (k = 0; mb(8'h44) !== 8'h00 && k < 3000; k++) @(negedge mclk);
		repeat (3) @(negedge mclk);
		chk(abort_active, 1'b1);
		done(24'h0000A0, mcq_pkg::RES_GOOD);
		wait_in(8'h4C, mcq_pkg::CC_ABORTED, 24'h0000A0);
		repeat (20) @(negedge mclk);
		chk(disp_valid, 1'b0);
	endtask : t_abort
	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		results();
	end
	initial begin
		{reset, slow, reg_wr, reg_rd, disp_ready, cmpl_valid, other_event} = 7'h40;
		{reg_addr, reg_wdata, cmpl_result, ast} = '0;
		errors = 0;
		n_tests = 0;
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		t_regs();
		t_first();
		t_busy();
		t_notfound();
		t_abort();
		results();
	end
endmodule : tb_top
`default_nettype wire
